/* File: core/stx_prescaler.sv */
// Baud generator input prescaler: one tick per 1, 4, 16 or 64 system clocks.
`timescale 1ns/1ns
`default_nettype none
module stx_prescaler import stx_pkg::*; #(
	parameter int CNT_W = 6
) (
	// Clock and control.
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	// Division select.
	input  wire logic [1:0] i_sel,
	// Tick out.
	output logic            o_tick
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} stx_pre_s;

	stx_pre_s   r_reg;
	stx_pre_s   r_next;
	logic [5:0] lim;

	// ==========================================================================
	// Elaboration check.
	// ==========================================================================
	if (CNT_W < 6) begin : g_bad_width
		$error("Prescaler counter narrower than six bits cannot divide by 64.");
	end

	// Limit lookup and counter; the count restarts at the limit.
	always_comb begin
		case (i_sel)
			2'h0:    lim = PRE_LIM1;
			2'h1:    lim = PRE_LIM4;
			2'h2:    lim = PRE_LIM16;
			default: lim = PRE_LIM64;
		endcase
		o_tick = (r_reg.cnt >= CNT_W'(lim));
		r_next = r_reg;
		r_next.cnt = o_tick ? '0 : r_reg.cnt + CNT_W'(1);
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg <= '0;
		end else if (i_ce) begin
			r_reg <= r_next;
		end
	end

	// Undivided selection ticks every cycle.
	property p_undivided;
		@(posedge i_clk) disable iff (i_rst)
		(i_sel == 2'h0) |-> o_tick;
	endproperty
	a_undivided: assert property (p_undivided) else $error("Undivided clock did not tick.");

	// Divide by four leaves three idle cycles after a tick.
	property p_div4;
		@(posedge i_clk) disable iff (i_rst)
		(i_sel == 2'h1 && o_tick && i_ce) ##1 (i_sel == 2'h1 && i_ce)[*3] |->
		!o_tick && !$past(o_tick) && !$past(o_tick, 2);
	endproperty
	a_div4: assert property (p_div4) else $error("Divide by four ticked too early.");

endmodule : stx_prescaler
`default_nettype wire

/* File: core/stx_top.sv */
// Serial transmit holding register, frame format register and character framer with APB access.
//
// Operation
// - Empty shifter takes held byte and starts sending.
// - Next byte may be loaded during sending.
// - Holding register readable and writable at any time.
// - Holding register resets and sleeps to all ones.
// - Mode register resets to zero, always accessible.
// - Mode bit 7 selects asynchronous or synchronous.
// - Mode bit 6 selects seven or eight bits, asynchronous only.
// - Seven-bit characters drop the held byte MSB.
// - Mode bit 5 enables parity, asynchronous only.
// - Mode bit 4 picks even or odd parity.
// - Parity makes ones count even or odd.
// - Mode bit 3 gives one or two stops, asynchronous only.
// - Receiver checks only the first stop bit.
// - Multiprocessor mode overrides parity settings.
// - Mode bits 1:0 divide clock 1, 4, 16, 64.
// - Shifter sends least significant bit first.
// - No transfer while holding empty flag is set.
// - Enabled holding write clears flag, starts sending.
`timescale 1ns/1ns
`default_nettype none
module stx_top import stx_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable and low-power entry.
	input  wire logic              I_CLK,
	input  wire logic              I_RST,
	input  wire logic              I_CE,
	input  wire logic              I_STBY,
	// APB slave.
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	// Serial line.
	input  wire logic              I_RXD,
	output logic                   O_TXD,
	output logic                   O_SCK
);

	typedef struct packed {
		logic [7:0]  mode;
		logic [7:0]  hold;
		logic        te;
		logic        re;
		logic        mpb_tx;
		logic [7:0]  div;
		logic        hold_empty;
		stx_tx_e     tx_st;
		logic [7:0]  sh;
		logic        xbit;
		logic [2:0]  tidx;
		logic [7:0]  bcnt;
		logic        txd;
		logic        sck;
		stx_rx_e     rx_st;
		logic [7:0]  rsh;
		logic [2:0]  ridx;
		logic [7:0]  rcnt;
		logic [7:0]  rdata;
		logic        rx_full;
		logic        par_err;
		logic        frm_err;
		logic        rx_mpb;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} stx_state_s;

	stx_state_s r_reg;
	stx_state_s r_next;
	logic       tick;
	logic       pre_clr;

	// ==========================================================================
	// Elaboration check.
	// ==========================================================================
	if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
		$error("Address width must be 5 to 8 bits to decode the register map.");
	end

	// ==========================================================================
	// Prescaler.
	// ==========================================================================
	stx_prescaler #(
		.CNT_W (6)
	) u_pre (
		.i_clk  (I_CLK),
		.i_rst  (pre_clr),
		.i_ce   (I_CE),
		.i_sel  (r_reg.mode[MODE_CKS_H:MODE_CKS_L]),
		.o_tick (tick)
	);

	// ==========================================================================
	// Next-state logic.
	// ==========================================================================
	logic       acc, commit, wr, wr_hold, hit;
	logic       sync, seven, xen, load, tbit_end, rbit_end, rhalf;
	logic [2:0] last;
	logic [7:0] hword, rbyte;
	logic [31:0] rd;

	// A load restarts the prescaler so the first bit of a frame has full length.
	// The receiver shares the tick, so its bit timing jumps when a frame starts.
	assign pre_clr = I_RST || (I_CE && load);

	// One process computes bus, transmit and receive next state together.
	always_comb begin
		r_next   = r_reg;
		acc      = I_PSEL && I_PENABLE;
		commit   = acc && r_reg.pready;
		wr       = commit && I_PWRITE;
		wr_hold  = wr && (I_PADDR == ADDR_W'(OFF_HOLD));
		sync     = r_reg.mode[MODE_SYNC];
		seven    = !sync && r_reg.mode[MODE_SEVEN];
		last     = seven ? LAST_BIT7 : LAST_BIT8;
		// Multiprocessor bit replaces parity; synchronous adds neither.
		xen      = !sync && (r_reg.mode[MODE_MP] || r_reg.mode[MODE_PAR]);
		hword    = seven ? {1'b0, r_reg.hold[6:0]} : r_reg.hold;
		tbit_end = tick && (r_reg.bcnt == r_reg.div);
		rbit_end = tick && (r_reg.rcnt == r_reg.div);
		rhalf    = tick && (r_reg.rcnt == (r_reg.div >> 1));
		rbyte    = seven ? {1'b0, r_reg.rsh[7:1]} : r_reg.rsh;
		load     = 1'b0;

		// Read mux; answered one cycle into the access phase.
		hit = 1'b1;
		rd  = '0;
		case (I_PADDR)
			ADDR_W'(OFF_MODE):   rd[7:0] = r_reg.mode;
			ADDR_W'(OFF_HOLD):   rd[7:0] = r_reg.hold;
			ADDR_W'(OFF_CTRL): begin
				rd[CTRL_TE]  = r_reg.te;
				rd[CTRL_RE]  = r_reg.re;
				rd[CTRL_MPB] = r_reg.mpb_tx;
				rd[CTRL_DIV_H:CTRL_DIV_L] = r_reg.div;
			end
			ADDR_W'(OFF_STATUS): begin
				rd[ST_EMPTY]  = r_reg.hold_empty;
				rd[ST_TEND]   = r_reg.hold_empty && (r_reg.tx_st == TX_IDLE);
				rd[ST_RXFULL] = r_reg.rx_full;
				rd[ST_PERR]   = r_reg.par_err;
				rd[ST_FERR]   = r_reg.frm_err;
				rd[ST_RXMPB]  = r_reg.rx_mpb;
			end
			ADDR_W'(OFF_RXDATA): rd[7:0] = r_reg.rdata;
			default:             hit = 1'b0;
		endcase
		if (acc && !r_reg.pready) begin
			r_next.pready  = 1'b1;
			r_next.prdata  = I_PWRITE ? 32'h0 : rd;
			r_next.pslverr = !hit;
		end else begin
			r_next.pready  = 1'b0;
			r_next.pslverr = 1'b0;
		end

		// Register writes take effect on the completing edge.
		if (wr) begin
			case (I_PADDR)
				ADDR_W'(OFF_MODE): r_next.mode = I_PWDATA[7:0];
				ADDR_W'(OFF_HOLD): r_next.hold = I_PWDATA[7:0];
				ADDR_W'(OFF_CTRL): begin
					r_next.te     = I_PWDATA[CTRL_TE];
					r_next.re     = I_PWDATA[CTRL_RE];
					r_next.mpb_tx = I_PWDATA[CTRL_MPB];
					r_next.div    = I_PWDATA[CTRL_DIV_H:CTRL_DIV_L];
				end
				default: ;
			endcase
		end

		// Transmit sequencer; a load waits a cycle behind a holding write so
		// the byte being written is never lost under the one being taken.
		if (r_reg.tx_st != TX_IDLE && tick) begin
			r_next.bcnt = tbit_end ? 8'h00 : r_reg.bcnt + 8'h01;
		end
		case (r_reg.tx_st)
			TX_IDLE: begin
				load = r_reg.te && !r_reg.hold_empty && !wr_hold;
			end
			TX_START: begin
				if (tbit_end) begin
					r_next.tx_st = TX_DATA;
					r_next.tidx  = 3'h0;
				end
			end
			TX_DATA: begin
				if (tbit_end) begin
					r_next.sh   = r_reg.sh >> 1;
					r_next.tidx = r_reg.tidx + 3'h1;
					if (r_reg.tidx == last) begin
						if (xen) begin
							r_next.tx_st = TX_XBIT;
						end else if (sync) begin
							load = r_reg.te && !r_reg.hold_empty && !wr_hold;
							r_next.tx_st = TX_IDLE;
						end else begin
							r_next.tx_st = TX_STOP1;
						end
					end
				end
			end
			TX_XBIT: begin
				if (tbit_end) begin
					r_next.tx_st = TX_STOP1;
				end
			end
			TX_STOP1: begin
				if (tbit_end) begin
					if (r_reg.mode[MODE_STOP2]) begin
						r_next.tx_st = TX_STOP2;
					end else begin
						load = r_reg.te && !r_reg.hold_empty && !wr_hold;
						r_next.tx_st = TX_IDLE;
					end
				end
			end
			TX_STOP2: begin
				if (tbit_end) begin
					load = r_reg.te && !r_reg.hold_empty && !wr_hold;
					r_next.tx_st = TX_IDLE;
				end
			end
			default: r_next.tx_st = TX_IDLE;
		endcase
		if (load) begin
			r_next.sh    = hword;
			r_next.tidx  = 3'h0;
			r_next.bcnt  = 8'h00;
			r_next.tx_st = sync ? TX_DATA : TX_START;
			// Parity over the sent bits, or the multiprocessor bit instead.
			r_next.xbit  = r_reg.mode[MODE_MP] ? r_reg.mpb_tx :
			               (^hword) ^ r_reg.mode[MODE_ODD];
		end

		// Empty flag: a load sets it, an enabled holding write clears it.
		if (!r_reg.te) begin
			r_next.hold_empty = 1'b1;
		end else begin
			r_next.hold_empty = (r_reg.hold_empty && !wr_hold) || load;
		end

		// Receiver for asynchronous frames, sampled at bit centres.
		if (r_reg.rx_st != RX_IDLE && tick) begin
			r_next.rcnt = rbit_end ? 8'h00 : r_reg.rcnt + 8'h01;
		end
		case (r_reg.rx_st)
			RX_IDLE: begin
				if (r_reg.re && !sync && !I_RXD) begin
					r_next.rx_st = RX_START;
					r_next.rcnt  = 8'h00;
				end
			end
			RX_START: begin
				if (rhalf) begin
					r_next.rx_st = I_RXD ? RX_IDLE : RX_DATA;
					r_next.rcnt  = 8'h00;
					r_next.ridx  = 3'h0;
				end
			end
			RX_DATA: begin
				if (rbit_end) begin
					r_next.rsh  = {I_RXD, r_reg.rsh[7:1]};
					r_next.ridx = r_reg.ridx + 3'h1;
					if (r_reg.ridx == last) begin
						r_next.rx_st = xen ? RX_XBIT : RX_STOP;
					end
				end
			end
			RX_XBIT: begin
				if (rbit_end) begin
					if (r_reg.mode[MODE_MP]) begin
						r_next.rx_mpb = I_RXD;
					end else if (((^rbyte) ^ I_RXD) != r_reg.mode[MODE_ODD]) begin
						r_next.par_err = 1'b1;
					end
					r_next.rx_st = RX_STOP;
				end
			end
			RX_STOP: begin
				// Only the first stop bit is looked at; a low bit after it is
				// picked up in idle as the next start bit.
				if (rbit_end) begin
					r_next.frm_err = r_reg.frm_err || !I_RXD;
					r_next.rdata   = rbyte;
					r_next.rx_full = 1'b1;
					r_next.rx_st   = RX_IDLE;
				end
			end
			default: r_next.rx_st = RX_IDLE;
		endcase

		// Write-one-to-clear of receive flags; a set in the same cycle wins only if the flag was low before it.
		if (wr && I_PADDR == ADDR_W'(OFF_STATUS)) begin
			r_next.rx_full = r_next.rx_full &&
			                 !(I_PWDATA[ST_RXFULL] && r_next.rx_full == r_reg.rx_full);
			r_next.par_err = r_next.par_err &&
			                 !(I_PWDATA[ST_PERR] && r_next.par_err == r_reg.par_err);
			r_next.frm_err = r_next.frm_err &&
			                 !(I_PWDATA[ST_FERR] && r_next.frm_err == r_reg.frm_err);
		end

		// Low-power entry returns the holding and mode registers to reset values.
		if (I_STBY) begin
			r_next.hold = HOLD_RST;
			r_next.mode = MODE_RST;
		end

		// Line outputs follow the next sequencer state.
		case (r_next.tx_st)
			TX_START: r_next.txd = 1'b0;
			TX_DATA:  r_next.txd = r_next.sh[0];
			TX_XBIT:  r_next.txd = r_next.xbit;
			default:  r_next.txd = 1'b1;
		endcase
		// The clock only toggles when a bit spans two ticks or more, so synchronous
		// mode needs a divider value of at least one.
		r_next.sck = !(sync && r_next.tx_st == TX_DATA && r_next.bcnt <= (r_reg.div >> 1));
	end

	// ==========================================================================
	// State register.
	// ==========================================================================
	// Reset loads constants only; the clock enable freezes everything.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			r_reg            <= '0;
			r_reg.mode       <= MODE_RST;
			r_reg.hold       <= HOLD_RST;
			r_reg.div        <= DIV_RST;
			r_reg.hold_empty <= 1'b1;
			r_reg.tx_st      <= TX_IDLE;
			r_reg.rx_st      <= RX_IDLE;
			r_reg.txd        <= 1'b1;
			r_reg.sck        <= 1'b1;
		end else if (I_CE) begin
			r_reg <= r_next;
		end
	end

	// Outputs come straight from the state register.
	assign O_PRDATA  = r_reg.prdata;
	assign O_PREADY  = r_reg.pready;
	assign O_PSLVERR = r_reg.pslverr;
	assign O_TXD     = r_reg.txd;
	assign O_SCK     = r_reg.sck;

	// ==========================================================================
	// Assertions.
	// ==========================================================================
	property p_load;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && !I_STBY && r_reg.tx_st == TX_IDLE && r_reg.te && !r_reg.hold_empty && !wr_hold)
		|=> (r_reg.tx_st != TX_IDLE) && r_reg.hold_empty && !O_TXD == !r_reg.mode[MODE_SYNC] ||
		    r_reg.mode[MODE_SYNC];
	endproperty
	a_load: assert property (p_load) else $error("Held byte was not taken by idle shifter.");

	property p_no_load;
		@(posedge I_CLK) disable iff (I_RST)
		(r_reg.tx_st == TX_IDLE && r_reg.hold_empty && !wr_hold) |=> r_reg.tx_st == TX_IDLE;
	endproperty
	a_no_load: assert property (p_no_load) else $error("Transfer started with empty flag set.");

	property p_wr_clear;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && wr_hold && r_reg.te && r_reg.tx_st != TX_IDLE) |=> !r_reg.hold_empty;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("Holding write left empty flag set.");

	property p_hold_rst;
		@(posedge I_CLK) (I_RST || (I_CE && I_STBY)) |=> r_reg.hold == HOLD_RST;
	endproperty
	a_hold_rst: assert property (p_hold_rst) else $error("Holding register not all ones.");

	property p_mode_rst;
		@(posedge I_CLK) (I_RST || (I_CE && I_STBY)) |=> r_reg.mode == MODE_RST;
	endproperty
	a_mode_rst: assert property (p_mode_rst) else $error("Mode register not cleared.");

	property p_frame_edges;
		@(posedge I_CLK) disable iff (I_RST)
		((r_reg.tx_st == TX_START) |-> !O_TXD) and
		((r_reg.tx_st inside {TX_IDLE, TX_STOP1, TX_STOP2}) |-> O_TXD);
	endproperty
	a_frame_edges: assert property (p_frame_edges) else $error("Start or stop level wrong.");

	property p_lsb_first;
		@(posedge I_CLK) disable iff (I_RST)
		(r_reg.tx_st == TX_DATA) |-> O_TXD == r_reg.sh[0] && (r_reg.tidx != 3'h7 || !seven);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("Data bit order or length wrong.");

	property p_sync_frame;
		@(posedge I_CLK) disable iff (I_RST)
		r_reg.mode[MODE_SYNC] && !$changed(r_reg.mode) |->
		!(r_reg.tx_st inside {TX_START, TX_XBIT, TX_STOP1, TX_STOP2}) || $past(r_reg.tx_st) != TX_DATA;
	endproperty
	a_sync_frame: assert property (p_sync_frame) else $error("Synchronous frame got framing bits.");

	property p_apb_answer;
		@(posedge I_CLK) disable iff (I_RST)
		(I_CE && I_PSEL && I_PENABLE && !O_PREADY) |=> O_PREADY;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("APB answer late.");

endmodule : stx_top
`default_nettype wire

/* File: dv/stx_remote.sv */
// Remote serial device model that captures transmitted frames bit by bit.
`timescale 1ns/1ns
`default_nettype none
module stx_remote (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Capture setup.
	input  wire logic        i_sync,
	input  wire logic [7:0]  i_len,
	input  wire logic [5:0]  i_nbits,
	// Serial line.
	input  wire logic        i_txd,
	input  wire logic        i_sck,
	output logic             o_rxd,
	// Captured frame.
	output logic [31:0]      o_bits,
	output logic             o_done
);
	logic       busy_reg;
	logic       sck_q_reg;
	logic [5:0] k_reg;
	int         t_reg;
	logic       act;
	logic       samp;
	int         t;

	// The line is looped back, so the block's receiver hears every frame it sends.
	assign o_rxd = i_txd;
	// A frame starts at the first low level; bits are taken mid-bit, sync bits on SCK rising.
	assign act  = busy_reg || (!i_sync && !i_txd);
	assign t    = busy_reg ? t_reg : 0;
	assign samp = i_sync ? (i_sck && !sck_q_reg)
		: (act && t == int'(i_len) * int'(k_reg) + int'(i_len) / 2);

	// Capture process; the bit index doubles as the position in the frame.
	always @(posedge i_clk) begin
		o_done    <= 1'b0;
		sck_q_reg <= i_sck;
		if (i_rst) begin
			busy_reg <= 1'b0;
			k_reg    <= 6'h00;
			t_reg    <= 0;
		end else begin
			busy_reg <= act && !i_sync;
			t_reg    <= t + 1;
			if (samp) begin
				o_bits[k_reg] <= i_txd;
				k_reg         <= k_reg + 6'h01;
				if (k_reg + 6'h01 == i_nbits) begin
					busy_reg <= 1'b0;
					k_reg    <= 6'h00;
					o_done   <= 1'b1;
				end
			end
		end
	end
endmodule : stx_remote
`default_nettype wire

/* File: dv/stx_top_tb.sv */
// Self-checking testbench of the serial transmit block over APB.
`timescale 1ns/1ns
`default_nettype none
module stx_top_tb import stx_pkg::*;;
	logic        clk = 1'b0, rst = 1'b1, stby = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, txd, sck, rxd, rem_done, rem_sync = 1'b0, err;
	logic [7:0]  paddr = 8'h00, rem_len = 8'h01;
	logic [5:0]  rem_n = 6'h0a;
	logic [31:0] pwdata = 32'h0, prdata, rem_bits;
	int          bad_count = 0, checks = 0, frames = 0;
	logic [7:0]  modes [12] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h70, 8'h08,
		8'h24, 8'h34, 8'h01, 8'h02, 8'h03, 8'he9};

	// ==========================================================================
	// Design, far-side model and clock.
	// ==========================================================================
	stx_top DUT (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_STBY(stby), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RXD(rxd),
		.O_TXD(txd), .O_SCK(sck));
	stx_remote remote (.i_clk(clk), .i_rst(rst), .i_sync(rem_sync), .i_len(rem_len),
		.i_nbits(rem_n), .i_txd(txd), .i_sck(sck), .o_rxd(rxd), .o_bits(rem_bits),
		.o_done(rem_done));
	always #10 clk = ~clk;
	// Frames seen by the far side, so stale bytes sent twice are caught.
	always @(posedge clk) if (rem_done === 1'b1) frames++;

	// ==========================================================================
	// Tasks.
	// ==========================================================================
	task automatic end_of_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer; request held until PREADY is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				bad_count++;
				end_of_test();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'b1, a, d, x);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		apb(1'b0, a, 32'h0, x);
		chk(nm, exp, x);
	endtask : rdc

	task automatic wait_done;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 2000) begin
				bad_count++;
				end_of_test();
			end
		end while (rem_done !== 1'b1);
	endtask : wait_done

	// Expected line bits of one character, worked out from the mode byte.
	function automatic logic [31:0] frame(input logic [7:0] m, input logic [7:0] d,
		input logic mpb, output int n);
		logic [31:0] b;
		int          nd;
		b = {24'hffffff, d};
		n = 8;
		if (m[MODE_SYNC]) return b;
		nd = m[MODE_SEVEN] ? 7 : 8;
		b[0] = 1'b0;
		for (int i = 0; i < nd; i++) b[i+1] = d[i];
		n = 1 + nd;
		if (m[MODE_MP] || m[MODE_PAR]) begin
			b[n] = m[MODE_MP] ? mpb : (^(d & (m[MODE_SEVEN] ? 8'h7f : 8'hff))) ^ m[MODE_ODD];
			n++;
		end
		n += m[MODE_STOP2] ? 2 : 1;
		return b;
	endfunction : frame

	// ==========================================================================
	// Main sequence.
	// ==========================================================================
	initial begin
		logic [31:0] e, e2;
		logic [7:0]  d;
		int          n, n2;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdc("mode rst", OFF_MODE, 32'h0);
		rdc("hold rst", OFF_HOLD, 32'hff);
		rdc("empty rst", OFF_STATUS, 32'h3);
		rdc("unmapped", 8'h20, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		$display("test reset done");
		// Every format option, prescaler and the sync mode with MP kept clear.
		foreach (modes[i]) begin
			d = 8'h5a + 8'(i) * 8'h27;
			e = frame(modes[i], d, i[0], n);
			rem_sync <= modes[i][MODE_SYNC];
			rem_len  <= 8'h01 << {modes[i][1:0], 1'b0};
			rem_n    <= 6'(n);
			wr(OFF_MODE, {24'h0, modes[i]});
			// Synchronous clock needs two ticks per bit to toggle, so the divider is one there.
			wr(OFF_CTRL, {16'h0, 8'(modes[i][MODE_SYNC]), 5'h0, i[0], 2'b01});
			wr(OFF_HOLD, {24'h0, d});
			wait_done();
			e2 = (32'h1 << n) - 32'h1;
			chk("frame", e & e2, rem_bits & e2);
			repeat (70) @(posedge clk);
		end
		chk("frame count", 32'd12, frames);
		$display("test formats done");
		// Two bytes written back to back leave the line with no idle gap.
		e  = frame(8'h01, 8'h96, 1'b0, n);
		e2 = frame(8'h01, 8'h5b, 1'b0, n2);
		rem_sync <= 1'b0;
		rem_len  <= 8'h04;
		rem_n    <= 6'd20;
		wr(OFF_MODE, 32'h01);
		// Receiver hears the looped-back line: a start right after the first stop.
		wr(OFF_CTRL, 32'h3);
		wr(OFF_HOLD, 32'h96);
		wr(OFF_HOLD, 32'h5b);
		wait_done();
		chk("two frames", {12'h0, e2[9:0], e[9:0]}, rem_bits & 32'hfffff);
		$display("test back to back done");
		// Transmitter off: holding still written, nothing sent.
		wr(OFF_CTRL, 32'h0);
		wr(OFF_HOLD, 32'h3c);
		rdc("hold rw", OFF_HOLD, 32'h3c);
		rdc("rx byte", OFF_RXDATA, 32'h5b);
		rdc("empty off", OFF_STATUS, 32'h7);
		repeat (200) @(posedge clk);
		chk("no frame", 32'd13, frames);
		wr(OFF_MODE, 32'h3c);
		rdc("mode rw", OFF_MODE, 32'h3c);
		@(posedge clk);
		stby <= 1'b1;
		repeat (2) @(posedge clk);
		stby <= 1'b0;
		rdc("hold stby", OFF_HOLD, 32'hff);
		rdc("mode stby", OFF_MODE, 32'h0);
		$display("test standby done");
		end_of_test();
	end
endmodule : stx_top_tb
`default_nettype wire

/* File: pkg/stx_pkg.sv */
// Package of constants and types for the serial transmit buffer and frame format block.
package stx_pkg;

	// ==========================================================================
	// Register byte offsets on the APB bus.
	// ==========================================================================
	localparam logic [7:0] OFF_MODE   = 8'h00;
	localparam logic [7:0] OFF_HOLD   = 8'h04;
	localparam logic [7:0] OFF_CTRL   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_RXDATA = 8'h10;

	// ==========================================================================
	// Reset values.
	// ==========================================================================
	localparam logic [7:0] HOLD_RST = 8'hff;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] DIV_RST  = 8'h00;

	// ==========================================================================
	// Field positions of the frame format mode register.
	// ==========================================================================
	localparam int MODE_SYNC  = 7;
	localparam int MODE_SEVEN = 6;
	localparam int MODE_PAR   = 5;
	localparam int MODE_ODD   = 4;
	localparam int MODE_STOP2 = 3;
	localparam int MODE_MP    = 2;
	localparam int MODE_CKS_H = 1;
	localparam int MODE_CKS_L = 0;

	// ==========================================================================
	// Field positions of the control and status registers.
	// ==========================================================================
	localparam int CTRL_TE    = 0;
	localparam int CTRL_RE    = 1;
	localparam int CTRL_MPB   = 2;
	localparam int CTRL_DIV_L = 8;
	localparam int CTRL_DIV_H = 15;
	localparam int ST_EMPTY   = 0;
	localparam int ST_TEND    = 1;
	localparam int ST_RXFULL  = 2;
	localparam int ST_PERR    = 3;
	localparam int ST_FERR    = 4;
	localparam int ST_RXMPB   = 5;

	// ==========================================================================
	// Last data bit indices and prescaler limits (cycles per tick minus one).
	// ==========================================================================
	localparam logic [2:0] LAST_BIT8 = 3'h7;
	localparam logic [2:0] LAST_BIT7 = 3'h6;
	localparam logic [5:0] PRE_LIM1  = 6'h00;
	localparam logic [5:0] PRE_LIM4  = 6'h03;
	localparam logic [5:0] PRE_LIM16 = 6'h0f;
	localparam logic [5:0] PRE_LIM64 = 6'h3f;

	// ==========================================================================
	// State encodings.
	// ==========================================================================
	typedef enum logic [5:0] {
		TX_IDLE  = 6'b000001,
		TX_START = 6'b000010,
		TX_DATA  = 6'b000100,
		TX_XBIT  = 6'b001000,
		TX_STOP1 = 6'b010000,
		TX_STOP2 = 6'b100000
	} stx_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_XBIT  = 5'b01000,
		RX_STOP  = 5'b10000
	} stx_rx_e;

endpackage : stx_pkg
